//--- inc/rtsam_regs.vh
// Subaddress service map constants for the remote terminal
`ifndef RTSAM_REGS_VH
`define RTSAM_REGS_VH
`define RTSAM_SA_MODE_LO 5'h00
`define RTSAM_SA_MODE_HI 5'h1F
`define RTSAM_SA_EVENT_A 5'h05
`define RTSAM_SA_EVENT_B 5'h06
`define RTSAM_SA_TIME 5'h08
`define RTSAM_SA_TMREQ 5'h0A
`define RTSAM_SA_TMDATA_FIRST 5'h0B
`define RTSAM_SA_TMDATA_LAST 5'h1A
`define RTSAM_SA_TCDATA_FIRST 5'h0B
`define RTSAM_SA_TCDATA_LAST 5'h0E
`define RTSAM_SA_TCDESC 5'h1B
`define RTSAM_SA_LLCMD 5'h1C
`define RTSAM_SA_WRAP 5'h1E
`define RTSAM_SVC_NONE 4'h0
`define RTSAM_SVC_EVENT 4'h1
`define RTSAM_SVC_TIME 4'h2
`define RTSAM_SVC_TMREQ 4'h3
`define RTSAM_SVC_TMDATA 4'h4
`define RTSAM_SVC_TCDATA 4'h5
`define RTSAM_SVC_TCDESC 4'h6
`define RTSAM_SVC_LLCMD 4'h7
`define RTSAM_SVC_WRAP 4'h8
`define RTSAM_SVC_MODE 4'h9
`define RTSAM_WORD_RESET 16'h0000
`endif

//--- core/rtsam_wrap_mem.v
// Data wrap buffer: words written on receive are read back on transmit
`timescale 1ns/1ps
`include "rtsam_regs.vh"
module rtsam_wrap_mem #(
    parameter DEPTH = 32,
    parameter AW = 5
) (
    clk,
    rstn,
    wrEn,
    wrIdx,
    wrData,
    rdIdx,
    rdData
);
    input wire clk;
    input wire rstn;
    input wire wrEn;
    input wire [AW-1:0] wrIdx;
    input wire [15:0] wrData;
    input wire [AW-1:0] rdIdx;
    output wire [15:0] rdData;

    reg [15:0] mem [0:DEPTH-1];
    reg [DEPTH-1:0] wordWritten_q;

    // Storage without reset keeps this a plain RAM
    always @(posedge clk) begin
        if (wrEn) begin
            mem[wrIdx] <= wrData;
        end
    end

    // Written marks clear on reset, so a read before any write returns zeros instead of stale RAM
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wordWritten_q <= {DEPTH{1'b0}};
        end else if (wrEn) begin
            wordWritten_q[wrIdx] <= 1'b1;
        end
    end

    // Combinational read; the caller registers it with the other transmit sources
    assign rdData = wordWritten_q[rdIdx] ? mem[rdIdx] : `RTSAM_WORD_RESET;
endmodule

//--- core/rtsam_service_map.v
// Subaddress service map of the remote terminal: routes data words by subaddress
// Summary of operation
// - Event packets up to 64 octets on 5T/6T
// - Transmit 8 reads internal time status
// - Telemetry transfer request served on 10T
// - Telemetry data on 11T-26T, MSB first
// - Telecommand data accepted on 11R-14R when not broadcast
// - Telecommand confirmation served on 27T
// - Low-level commands arrive on 28R
// - Low-level command status on 28T
// - Data wrap on 30R and 30T; broadcast 30R words are not stored
// - Subaddresses 0 and 31 mean mode commands
// - T/R bit zero receives, one transmits
`timescale 1ns/1ps
`include "rtsam_regs.vh"
module rtsam_service_map #(
    parameter WRAP_DEPTH = 32,
    parameter EVENT_OCTETS = 64
) (
    input wire clk,
    input wire rstn,
    input wire wordValid,
    input wire trBit,
    input wire [4:0] subaddress,
    input wire [4:0] wordIdx,
    input wire [15:0] rxWord,
    input wire bcast,
    input wire [15:0] eventAWord,
    input wire [15:0] eventBWord,
    input wire [15:0] timeWord,
    input wire [15:0] tmReqWord,
    input wire [15:0] tmDataWord,
    input wire [15:0] tcConfWord,
    input wire [15:0] llStatusWord,
    output reg [15:0] txWord,
    output reg txValid,
    output reg [3:0] service,
    output reg modeCmd,
    output reg unusedSa,
    output reg eventAck,
    output reg eventAckB,
    output reg timeStrobe,
    output reg tmConfStrobe,
    output reg tcDataStrobe,
    output reg [1:0] tcDataPart,
    output reg tcDescStrobe,
    output reg llCmdStrobe,
    output reg [15:0] rxWordOut,
    output reg [3:0] tmDataPart,
    output reg eventTooLong
);
    localparam WORD_LIMIT = EVENT_OCTETS / 2;

    wire [15:0] wrapRd;
    reg [3:0] svc;
    reg [15:0] txSel;

    // Classify a subaddress and direction into a service code
    function [3:0] classify;
        input [4:0] sa;
        input tr;
        begin
            if (sa == `RTSAM_SA_MODE_LO || sa == `RTSAM_SA_MODE_HI) begin
                classify = `RTSAM_SVC_MODE;
            end else if (sa == `RTSAM_SA_EVENT_A || sa == `RTSAM_SA_EVENT_B) begin
                classify = `RTSAM_SVC_EVENT;
            end else if (sa == `RTSAM_SA_TIME) begin
                classify = `RTSAM_SVC_TIME;
            end else if (sa == `RTSAM_SA_TMREQ) begin
                classify = `RTSAM_SVC_TMREQ;
            end else if (tr && sa >= `RTSAM_SA_TMDATA_FIRST && sa <= `RTSAM_SA_TMDATA_LAST) begin
                classify = `RTSAM_SVC_TMDATA;
            end else if (!tr && sa >= `RTSAM_SA_TCDATA_FIRST && sa <= `RTSAM_SA_TCDATA_LAST) begin
                classify = `RTSAM_SVC_TCDATA;
            end else if (sa == `RTSAM_SA_TCDESC) begin
                classify = `RTSAM_SVC_TCDESC;
            end else if (sa == `RTSAM_SA_LLCMD) begin
                classify = `RTSAM_SVC_LLCMD;
            end else if (sa == `RTSAM_SA_WRAP) begin
                classify = `RTSAM_SVC_WRAP;
            end else begin
                classify = `RTSAM_SVC_NONE;
            end
        end
    endfunction

    // Transmit source selection by service
    always @* begin
        svc = classify(subaddress, trBit);
        case (svc)
            `RTSAM_SVC_EVENT: begin
                txSel = (subaddress == `RTSAM_SA_EVENT_A) ? eventAWord : eventBWord;
            end
            `RTSAM_SVC_TIME: begin
                txSel = timeWord;
            end
            `RTSAM_SVC_TMREQ: begin
                txSel = tmReqWord;
            end
            `RTSAM_SVC_TMDATA: begin
                txSel = tmDataWord;
            end
            `RTSAM_SVC_TCDESC: begin
                txSel = tcConfWord;
            end
            `RTSAM_SVC_LLCMD: begin
                txSel = llStatusWord;
            end
            `RTSAM_SVC_WRAP: begin
                txSel = wrapRd;
            end
            default: begin
                txSel = `RTSAM_WORD_RESET;
            end
        endcase
    end

    // Wrap words are kept per word index; reads return the last write at that index since reset, zeros before
    rtsam_wrap_mem #(
        .DEPTH(WRAP_DEPTH),
        .AW(5)
    ) uWrap (
        .clk(clk),
        .rstn(rstn),
        .wrEn(wordValid && !trBit && svc == `RTSAM_SVC_WRAP && !bcast),
        .wrIdx(wordIdx),
        .wrData(rxWord),
        .rdIdx(wordIdx),
        .rdData(wrapRd)
    );

    // Slot qualifiers by direction
    wire rxSlot;
    wire txSlot;
    assign rxSlot = wordValid && !trBit;
    assign txSlot = wordValid && trBit;

    // Services that answer a transmit command; mode codes and unused subaddresses get no data word
    function servesData;
        input [3:0] code;
        begin
            servesData = code != `RTSAM_SVC_MODE && code != `RTSAM_SVC_NONE;
        end
    endfunction

    // Service code and refusal flags, one cycle after the word is offered
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            service <= `RTSAM_SVC_NONE;
            modeCmd <= 1'h0;
            unusedSa <= 1'h0;
        end else begin
            service <= wordValid ? svc : `RTSAM_SVC_NONE;
            modeCmd <= wordValid && svc == `RTSAM_SVC_MODE;
            unusedSa <= wordValid && svc == `RTSAM_SVC_NONE;
        end
    end

    // Transmit word and flag; the word loads every cycle and only counts while the flag is high
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            txWord <= `RTSAM_WORD_RESET;
            txValid <= 1'h0;
        end else begin
            txValid <= txSlot && servesData(svc);
            txWord <= txSel;
        end
    end

    // Event words past one message of the configured size are flagged but still served as packet data;
    // with the default of 64 octets a five-bit word index never reaches the limit
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eventTooLong <= 1'h0;
        end else begin
            eventTooLong <= txSlot && svc == `RTSAM_SVC_EVENT && {27'h0, wordIdx} >= WORD_LIMIT;
        end
    end

    // Part indices track the subaddress every cycle; they mean something only beside their strobe
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tmDataPart <= 4'h0;
            tcDataPart <= 2'h0;
        end else begin
            tmDataPart <= subaddress[3:0] - 4'hB;
            tcDataPart <= subaddress[1:0] - 2'h3;
        end
    end

    // Receive strobes, one cycle wide, only when T/R is zero
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            eventAck <= 1'h0;
            eventAckB <= 1'h0;
            timeStrobe <= 1'h0;
            tmConfStrobe <= 1'h0;
            tcDataStrobe <= 1'h0;
            tcDescStrobe <= 1'h0;
            llCmdStrobe <= 1'h0;
        end else begin
            eventAck <= rxSlot && subaddress == `RTSAM_SA_EVENT_A;
            eventAckB <= rxSlot && subaddress == `RTSAM_SA_EVENT_B;
            timeStrobe <= rxSlot && svc == `RTSAM_SVC_TIME;
            tmConfStrobe <= rxSlot && svc == `RTSAM_SVC_TMREQ;
            tcDataStrobe <= rxSlot && svc == `RTSAM_SVC_TCDATA && !bcast;
            tcDescStrobe <= rxSlot && svc == `RTSAM_SVC_TCDESC;
            llCmdStrobe <= rxSlot && svc == `RTSAM_SVC_LLCMD;
        end
    end

    // Received word copy; loads every cycle because the strobes say when it is meaningful
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rxWordOut <= `RTSAM_WORD_RESET;
        end else begin
            rxWordOut <= rxWord;
        end
    end
endmodule

//--- testbench/rtsam_service_map_asserts.sv
// Port checker for the subaddress service map
`timescale 1ns/1ps
`include "rtsam_regs.vh"
module rtsam_service_map_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic wordValid, trBit, bcast, txValid, modeCmd, unusedSa, eventAck,
    input wire logic timeStrobe, tmConfStrobe, tcDataStrobe, tcDescStrobe, llCmdStrobe,
    input wire logic [4:0] subaddress,
    input wire logic [15:0] rxWord, tmReqWord, tmDataWord, txWord, rxWordOut,
    input wire logic [3:0] service, tmDataPart,
    input wire logic [1:0] tcDataPart
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);
    // Receive and transmit word slots, split by direction bit
    wire rx = wordValid && !trBit;
    wire tx = wordValid && trBit;
    chk_mode_refused: assert property (wordValid && subaddress inside {5'h00, 5'h1F} |=> modeCmd && !txValid)
        else $error("mode subaddress served as data");
    chk_event_ack: assert property (rx && !bcast && subaddress == 5'h05 |=> eventAck)
        else $error("event acknowledge missing");
    chk_time_bcast: assert property (rx && bcast && subaddress == 5'h08 |=> timeStrobe)
        else $error("time message missing");
    chk_tm_request: assert property (tx && subaddress == 5'h0A |=>
        txValid && txWord == $past(tmReqWord) && service == `RTSAM_SVC_TMREQ)
        else $error("transfer request word wrong");
    chk_tm_order: assert property (tx && subaddress inside {[5'h0B:5'h1A]} |=>
        txWord == $past(tmDataWord) && tmDataPart == 4'($past(subaddress) - 5'h0B))
        else $error("telemetry part wrong");
    chk_tc_part: assert property (rx && !bcast && subaddress inside {[5'h0B:5'h0E]} |=>
        tcDataStrobe && tcDataPart == 2'($past(subaddress) - 5'h0B))
        else $error("telecommand part wrong");
    chk_tc_desc: assert property (rx && !bcast && subaddress == 5'h1B |=> tcDescStrobe)
        else $error("descriptor strobe missing");
    chk_low_level: assert property (rx && !bcast && subaddress == 5'h1C |=>
        llCmdStrobe && rxWordOut == $past(rxWord))
        else $error("low level command lost");
    chk_unused_tx: assert property (tx && subaddress inside {5'h02, 5'h03, 5'h04, 5'h07, 5'h09, 5'h1D} |=>
        unusedSa && !txValid)
        else $error("unused transmit served");
    chk_time_read: assert property (tx && subaddress == 5'h08 |=>
        txValid && service == `RTSAM_SVC_TIME) else $error("time read not served");
    chk_tm_confirm: assert property (rx && subaddress == 5'h0A |=> tmConfStrobe && !txValid)
        else $error("telemetry confirmation missing");
    chk_wrap_served: assert property (tx && subaddress == 5'h1E |=>
        txValid && service == `RTSAM_SVC_WRAP) else $error("wrap read not served");
    chk_tx_cause: assert property (txValid |-> $past(wordValid) && $past(trBit))
        else $error("transmit word without transmit slot");
    // Main traffic kinds seen at least once
    cover property (timeStrobe);
    cover property (modeCmd);
    cover property (tcDataStrobe && tcDataPart == 2'h3);
    cover property (txValid && service == `RTSAM_SVC_WRAP);
endmodule

bind rtsam_service_map rtsam_service_map_chk chk_i (.clk, .rstn, .wordValid, .trBit, .bcast, .txValid, .modeCmd,
    .unusedSa, .eventAck, .timeStrobe, .tmConfStrobe, .tcDataStrobe, .tcDescStrobe, .llCmdStrobe, .subaddress, .rxWord,
    .tmReqWord, .tmDataWord, .txWord, .rxWordOut, .service, .tmDataPart, .tcDataPart);

//--- testbench/rtsam_bc_model.sv
// Bus controller model: hands one data word slot at a time to the terminal
`timescale 1ns/1ps
module rtsam_bc_model (
    input wire logic clk,
    output logic wordValid, trBit, bcast,
    output logic [4:0] subaddress, wordIdx,
    output logic [15:0] rxWord
);
    initial {wordValid, trBit, bcast, subaddress, wordIdx, rxWord} = '0;
    // Slot set after a falling edge and held across the taking rising edge
    task automatic send(input logic tr, input logic [4:0] sa, idx, input logic [15:0] data, input logic bc);
        @(negedge clk);
        trBit = tr;
        subaddress = sa;
        bcast = bc;
        {wordIdx, rxWord} = {idx, data};
        wordValid = 1'b1;
        @(negedge clk);
        wordValid = 1'b0;
        rxWord = ~rxWord; // Released data is scrambled so a stale word never matches
    endtask
endmodule

//--- testbench/rtsam_service_map_bench.sv
// Self-checking bench: sweeps and randomly hits every subaddress in both directions
`timescale 1ns/1ps
module rtsam_service_map_bench;
    logic clk = 1'b0, rstn = 1'b0, tr, skip;
    logic [15:0] eventAWord = 16'h0000, eventBWord = 16'h0000, timeWord = 16'h0000, tmReqWord = 16'h0000;
    logic [15:0] tmDataWord = 16'h0000, tcConfWord = 16'h0000, llStatusWord = 16'h0000, data;
    logic [4:0] sa, idx;
    logic [16:0] ex;
    logic [15:0] wrapMem [32];
    logic [31:0] wrapSet = 32'h00000000;
    wire wordValid, trBit, bcast, txValid, modeCmd, unusedSa, eventAck, eventAckB, timeStrobe, tmConfStrobe;
    wire tcDataStrobe, tcDescStrobe, llCmdStrobe, eventTooLong;
    wire [4:0] subaddress, wordIdx;
    wire [15:0] rxWord, txWord, rxWordOut;
    wire [3:0] service, tmDataPart;
    wire [1:0] tcDataPart;
    int n_errors = 0, total_checks = 0, cycles = 0;
    rtsam_bc_model bc (.clk, .wordValid, .trBit, .bcast, .subaddress, .wordIdx, .rxWord);
    rtsam_service_map DUT (.clk, .rstn, .wordValid, .trBit, .subaddress, .wordIdx, .rxWord, .bcast, .eventAWord,
        .eventBWord, .timeWord, .tmReqWord, .tmDataWord, .tcConfWord, .llStatusWord, .txWord, .txValid, .service,
        .modeCmd, .unusedSa, .eventAck, .eventAckB, .timeStrobe, .tmConfStrobe, .tcDataStrobe, .tcDataPart,
        .tcDescStrobe, .llCmdStrobe, .rxWordOut, .tmDataPart, .eventTooLong);
    initial forever #5 clk = ~clk;
    task automatic wrap_up();
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, exp);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Expected transmit word with its valid flag in the top bit
    function automatic logic [16:0] exp_tx(input logic t, input logic [4:0] s);
        if (!t) return '0;
        case (s)
            5'h05: return {1'b1, eventAWord};
            5'h06: return {1'b1, eventBWord};
            5'h08: return {1'b1, timeWord};
            5'h0A: return {1'b1, tmReqWord};
            5'h1B: return {1'b1, tcConfWord};
            5'h1C: return {1'b1, llStatusWord};
            5'h1E: return {1'b1, wrapSet[idx] ? wrapMem[idx] : 16'h0000};
            default: return s inside {[5'h0B:5'h1A]} ? {1'b1, tmDataWord} : '0;
        endcase
    endfunction
    function automatic logic [6:0] exp_rx(input logic t, input logic [4:0] s);
        return t ? '0 : {s == 5'h05, s == 5'h06, s == 5'h08, s == 5'h0A, s inside {[5'h0B:5'h0E]}, s == 5'h1B,
            s == 5'h1C};
    endfunction
    // Hang guard: the whole run needs about 600 cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            n_errors++;
            wrap_up();
        end
    end
    initial begin
        void'($urandom(32'hEF7B));
        repeat (20) @(posedge clk);
        @(negedge clk) rstn = 1'b1;
        // Sweep of every subaddress both ways, random picks, then a wrap echo cut by a reset
        for (int k = 0; k < 272; k++) begin
            if (k == 270) begin
                @(negedge clk) rstn = 1'b0;
                @(negedge clk) cmp({txValid, modeCmd, unusedSa, service}, 16'h0000);
                cmp(txWord, 16'h0000);
                rstn = 1'b1;
                wrapSet = 32'h00000000;
            end
            tr = k < 64 ? k[5] : k >= 264 ? k >= 268 : 1'($urandom);
            sa = k < 64 ? k[4:0] : k >= 264 ? 5'h1E : 5'($urandom);
            idx = k >= 264 ? 5'(k[1:0]) : 5'($urandom);
            data = 16'($urandom);
            {eventAWord, eventBWord, timeWord, tmReqWord} = {$urandom, $urandom};
            {tmDataWord, tcConfWord, llStatusWord} = {$urandom, 16'($urandom)};
            bc.send(tr, sa, idx, data, !tr && sa == 5'h08);
            skip = sa == 5'h01 || (!tr && sa inside {5'h03, 5'h04});
            ex = exp_tx(tr, sa);
            if (!tr && sa == 5'h1E) {wrapSet[idx], wrapMem[idx]} = {1'b1, data};
            cmp(modeCmd, sa inside {5'h00, 5'h1F});
            cmp({eventTooLong, eventAck, eventAckB, timeStrobe, tmConfStrobe, tcDataStrobe, tcDescStrobe,
                llCmdStrobe}, {1'b0, exp_rx(tr, sa)});
            if (!skip) cmp(txValid, ex[16]);
            if (!skip) cmp(unusedSa, tr ? sa inside {2, 3, 4, 7, 9, 29} : sa inside {2, 7, 9, [15:26], 29});
            if (ex[16]) cmp(txWord, ex[15:0]);
            if (tr && sa inside {[11:26]}) cmp(tmDataPart, sa - 5'h0B);
            if (!tr && sa inside {[11:14]}) cmp(tcDataPart, sa - 5'h0B);
            if (!tr && sa == 5'h1C) cmp(rxWordOut, data);
        end
        wrap_up();
    end
endmodule
